// *** rtl/sram_host_map.svh ***
`ifndef SRAM_HOST_MAP_SVH
`define SRAM_HOST_MAP_SVH
// Clock period in ps (25 MHz)
`define CLK_PERIOD_PS 40000
// Pin timing of the memory, in ns, fast grade then slow grade
`define T_RC_FAST_NS 55
`define T_RC_SLOW_NS 70
`define T_AA_FAST_NS 55
`define T_AA_SLOW_NS 70
`define T_AW_FAST_NS 45
`define T_AW_SLOW_NS 50
`define T_DW_FAST_NS 25
`define T_DW_SLOW_NS 30
`define T_WP_FAST_NS 30
`define T_WP_SLOW_NS 35
`define T_AS_NS 5
`define T_DH_NS 5
`define T_WR_NS 5
`define T_HZ_MAX_NS 25
`define T_OW_MAX_FAST_NS 30
`define T_OW_MAX_SLOW_NS 35
// Cycle counts: least times rounded up, never below one
`define CYC_MIN(ns) ((((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
	(((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`define MEM_ADDR_W 16
`define MEM_DATA_W 4
`endif

// *** rtl/sram_host_pkg.sv ***
package sram_host_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_GAP
	} phase_e;
	typedef logic [7:0] count_t;
endpackage

// *** rtl/phase_timer.sv ***
`timescale 1ns/1ps
// Down counter marking the end of each timed phase
module phase_timer
	import sram_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic load,
	input wire count_t loadValue,
	output logic done
);
	typedef struct packed {
		count_t cnt;
	} timer_s;
	timer_s s_q;
	timer_s s_d;

	// Load wins over counting so a new phase always restarts cleanly
	always_comb begin
		s_d = s_q;
		if (load) begin
			s_d.cnt = loadValue;
		end else if (s_q.cnt != 8'h00) begin
			s_d.cnt = s_q.cnt - 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = (s_q.cnt == 8'h00) && !load;
endmodule

// *** rtl/sram_host_ctrl.sv ***
`timescale 1ns/1ps
`include "sram_host_map.svh"
// Operation
// R01: Write enable stays high for the whole read cycle.
// R02: Read cycle lasts at least 55 ns or 70 ns per grade.
// R03: Memory gives data 55/70 ns after stable address, select held low.
// R04: Memory gives data 55/70 ns after select falls, address already valid.
// R05: Memory holds old data at least 5 ns after address change.
// R06: Memory output stays high impedance at least 10 ns after select falls.
// R07: Memory output floats 5 to 25 ns after select rises.
// R08: Select or write enable high whenever any address line changes.
// R09: Write address valid at least 45/50 ns before write end.
// R10: Select low at least 45/50 ns before write ends.
// R11: Write data stable 25/30 ns before end, held 5 ns after.
// R12: Address held at least 5 ns after the write ends.
// R13: Output stays floating when select and write enable rise together.
// R14: Memory is fully static, driven only by pin levels and edges.
// R15: Memory holds 65,536 four-bit words, powers down when deselected.
// R16: Write enable low at least 30/35 ns; write cycle at least 55/70 ns.
// R17: Memory powers down within 40 ns of deselect, wakes at once.
// R18: Output off within 25 ns of write enable low, on 5 ns after rise.
module sram_host_ctrl
	import sram_host_pkg::*;
#(
	parameter int ADDR_W = `MEM_ADDR_W,
	parameter int DATA_W = `MEM_DATA_W,
	parameter bit SLOW_GRADE = 1'b0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqWdata,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspRdata,
	output logic [ADDR_W-1:0] memAddr,
	output logic memSelN,
	output logic memWrEnN,
	output logic [DATA_W-1:0] memDin,
	input wire logic [DATA_W-1:0] memDout
);
	////////////////////////////////////////////////////////////////////////
	// Phase lengths in cycles, chosen per grade
	// Whole cycles covering a least time, never below one
	function automatic int cycles(input int ns);
		return `CYC_MIN(ns);
	endfunction

	// Larger of two cycle counts
	function automatic int maxOf(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int RD_NS = SLOW_GRADE ? `T_AA_SLOW_NS : `T_AA_FAST_NS;
	localparam int RC_NS = SLOW_GRADE ? `T_RC_SLOW_NS : `T_RC_FAST_NS;
	localparam int WP_NS = SLOW_GRADE ? `T_WP_SLOW_NS : `T_WP_FAST_NS;
	localparam int AW_NS = SLOW_GRADE ? `T_AW_SLOW_NS : `T_AW_FAST_NS;
	localparam int DW_NS = SLOW_GRADE ? `T_DW_SLOW_NS : `T_DW_FAST_NS;
	localparam int OW_NS = SLOW_GRADE ? `T_OW_MAX_SLOW_NS : `T_OW_MAX_FAST_NS;
	// Access window must also span the whole read cycle
	localparam int RD_RAW = maxOf(cycles(RD_NS), cycles(RC_NS));
	// Two extra cycles cover the input synchroniser
	localparam count_t RD_CYC = count_t'(RD_RAW + 2);
	localparam count_t AS_CYC = count_t'(cycles(`T_AS_NS));
	// Pulse covers write enable width, data setup and the rest of address setup
	localparam int WP_C = cycles(AW_NS) - cycles(`T_AS_NS);
	localparam count_t WP_CYC = count_t'(maxOf(maxOf(cycles(WP_NS), cycles(DW_NS)), WP_C));
	// Hold covers both data hold and write recovery
	localparam count_t HOLD_CYC = count_t'(maxOf(cycles(`T_DH_NS), cycles(`T_WR_NS)));
	// Gap lets the memory output float before the next access
	localparam count_t GAP_CYC = count_t'(maxOf(cycles(`T_HZ_MAX_NS), cycles(OW_NS)));

	// Controller state, all but the timer count, in one flop set, so outputs need no logic after it
	typedef struct packed {
		phase_e phase;
		logic ready;
		logic rsp;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] addr;
		logic selN;
		logic wrEnN;
		logic [DATA_W-1:0] din;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
		logic tLoad;
		count_t tVal;
	} ctrl_s;

	// State register and its next value, filled by one always_comb
	ctrl_s s_q;
	ctrl_s s_d;
	logic tDone;

	////////////////////////////////////////////////////////////////////////
	// Phase timer
	// One timer serves every phase but idle; a load value of N spans N + 2 cycles
	phase_timer u_timer (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.load(s_q.tLoad),
		.loadValue(s_q.tVal),
		.done(tDone)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		s_d = s_q;
		// Pulses drop unless set again below
		s_d.rsp = 1'b0;
		s_d.tLoad = 1'b0;
		// Memory data is asynchronous to ref_clk
		s_d.sync1 = memDout;
		s_d.sync2 = s_q.sync1;
		case (s_q.phase)
			ST_IDLE: begin
				// Taken only while idle; nothing is queued
				if (reqValid && s_q.ready) begin
					s_d.ready = 1'b0;
					s_d.addr = reqAddr;
					s_d.tLoad = 1'b1;
					if (reqWrite) begin
						// R08: address moves only while write enable high
						s_d.wrEnN = 1'b1;
						s_d.selN = 1'b0;
						s_d.din = reqWdata;
						s_d.tVal = AS_CYC;
						s_d.phase = ST_WR_SETUP;
					end else begin
						// R01: write enable high in reads
						s_d.wrEnN = 1'b1;
						s_d.selN = 1'b0;
						// R02: read cycle length held
						s_d.tVal = RD_CYC;
						s_d.phase = ST_RD_WAIT;
					end
				end
			end
			ST_RD_WAIT: begin
				// Data has passed both sync flops by now
				if (tDone) begin
					s_d.rdata = s_q.sync2;
					s_d.rsp = 1'b1;
					s_d.selN = 1'b1;
					s_d.tLoad = 1'b1;
					s_d.tVal = GAP_CYC;
					s_d.phase = ST_GAP;
				end
			end
			ST_WR_SETUP: begin
				// Address and data settle before write enable falls
				if (tDone) begin
					// R16: write pulse width
					s_d.wrEnN = 1'b0;
					s_d.tLoad = 1'b1;
					// R09: address valid before end
					// R10: select low before end
					// R11: data setup before end
					s_d.tVal = WP_CYC;
					s_d.phase = ST_WR_PULSE;
				end
			end
			ST_WR_PULSE: begin
				if (tDone) begin
					// R13: both rise together, no read burst
					s_d.wrEnN = 1'b1;
					s_d.selN = 1'b1;
					s_d.tLoad = 1'b1;
					s_d.tVal = HOLD_CYC;
					s_d.phase = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				// R12: address and data held after end
				if (tDone) begin
					s_d.rsp = 1'b1;
					s_d.tLoad = 1'b1;
					s_d.tVal = GAP_CYC;
					s_d.phase = ST_GAP;
				end
			end
			ST_GAP: begin
				// Ready again only once the memory output has floated
				if (tDone) begin
					s_d.ready = 1'b1;
					s_d.phase = ST_IDLE;
				end
			end
			default: begin
				// Unused codes park the bus idle
				s_d.phase = ST_IDLE;
				s_d.selN = 1'b1;
				s_d.wrEnN = 1'b1;
				s_d.ready = 1'b1;
			end
		endcase
	end

	// Strobes idle high so the memory sits powered down after reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.phase <= ST_IDLE;
			s_q.ready <= 1'b1;
			s_q.selN <= 1'b1;
			s_q.wrEnN <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs read the state flops directly
	assign reqReady = s_q.ready;
	assign rspValid = s_q.rsp;
	assign rspRdata = s_q.rdata;
	assign memAddr = s_q.addr;
	assign memSelN = s_q.selN;
	assign memWrEnN = s_q.wrEnN;
	assign memDin = s_q.din;
endmodule

// *** tb/sram_model.sv ***
`timescale 1ns/1ps
// Behavioural memory, answers at the slow edge of the access window
module sram_model #(
	parameter bit SLOW = 1'b0
) (
	input wire logic [15:0] memAddr,
	input wire logic memSelN,
	input wire logic memWrEnN,
	input wire logic [3:0] memDin,
	output logic [3:0] memDout
);
	logic [3:0] cells [0:65535];
	int tok = 0;
	initial memDout = 4'h5;
	// store while both strobes low, level driven
	always @* begin
		if (!memSelN && !memWrEnN) cells[memAddr] = memDin;
	end
	// old data dies after 5 ns, junk until access time
	always @(memAddr or memSelN or memWrEnN) begin
		tok = tok + 1;
		fork
			begin
				automatic int t = tok;
				#5 memDout = ~memDout;
				#(SLOW ? 65 : 50);
				if (t == tok && !memSelN && memWrEnN) memDout = cells[memAddr];
			end
		join_none
	end
endmodule

// *** tb/sram_host_ctrl_checker.sv ***
`timescale 1ns/1ps
module sram_host_ctrl_checker #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 4
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic memSelN,
	input wire logic memWrEnN,
	input wire logic [DATA_W-1:0] memDin
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_take_busy: assert property (reqValid && reqReady |=> !reqReady)
		else $error("ready after take");
	chk_read_we_high: assert property (reqValid && reqReady && !reqWrite |=> memWrEnN [*7])
		else $error("write enable low in read");
	chk_read_length: assert property (reqValid && reqReady && !reqWrite
		|=> !memSelN [*6] ##1 memSelN) else $error("read cycle length");
	chk_addr_quiet: assert property ($changed(memAddr) |-> memWrEnN && $past(memWrEnN))
		else $error("address moved while writing");
	chk_sel_hold: assert property ($fell(memSelN) |=> !memSelN)
		else $error("select too short");
	chk_wr_setup: assert property ($fell(memWrEnN) |-> !memSelN && $past(!memSelN))
		else $error("write without select setup");
	chk_wr_pulse: assert property ($fell(memWrEnN) |=> !memWrEnN ##1 !memWrEnN ##1 memWrEnN)
		else $error("write pulse width");
	chk_wr_end: assert property ($rose(memWrEnN) |-> $rose(memSelN) && $past(!memSelN, 3))
		else $error("write end");
	chk_din_hold: assert property ($rose(memWrEnN)
		|-> $stable(memDin) ##1 $stable({memDin, memAddr}))
		else $error("data or address not held");
	chk_rsp_idle: assert property (rspValid |-> memSelN && memWrEnN ##1 !rspValid)
		else $error("bus busy at answer");
	cov_write: cover property ($rose(memWrEnN));
	cov_read: cover property ($fell(memSelN) && memWrEnN);
	cov_rsp: cover property (rspValid);
endmodule
bind sram_host_ctrl sram_host_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.ref_clk,
	.nrst, .reqValid, .reqWrite, .reqReady, .rspValid, .memAddr, .memSelN, .memWrEnN, .memDin);

// *** tb/async_sram_rw_cycle_timing_tb_top.sv ***
`timescale 1ns/1ps
module async_sram_rw_cycle_timing_tb_top;
	logic ref_clk = 0;
	logic nrst = 0;
	logic reqValid = 0;
	logic reqWrite = 0;
	logic [15:0] reqAddr = '0;
	logic [3:0] reqWdata = '0;
	logic reqReady, rspValid, memSelN, memWrEnN;
	logic [3:0] rspRdata, memDin, memDout;
	logic [15:0] memAddr;
	logic slowReady, slowRsp, slowSelN, slowWrEnN;
	logic [3:0] slowRdata, slowDin, slowDout;
	logic [15:0] slowAddr;
	int nMismatch = 0;
	int nTests = 0;
	sram_host_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
		.rspValid(rspValid), .rspRdata(rspRdata), .memAddr(memAddr), .memSelN(memSelN),
		.memWrEnN(memWrEnN), .memDin(memDin), .memDout(memDout));
	sram_model mem (.memAddr(memAddr), .memSelN(memSelN), .memWrEnN(memWrEnN),
		.memDin(memDin), .memDout(memDout));
	// Slow grade on the same requests; at 40 ns both grades round to equal counts
	sram_host_ctrl #(.SLOW_GRADE(1'b1)) dutSlow (.ref_clk(ref_clk), .nrst(nrst),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.reqReady(slowReady), .rspValid(slowRsp), .rspRdata(slowRdata), .memAddr(slowAddr),
		.memSelN(slowSelN), .memWrEnN(slowWrEnN), .memDin(slowDin), .memDout(slowDout));
	sram_model #(.SLOW(1'b1)) memSlow (.memAddr(slowAddr), .memSelN(slowSelN),
		.memWrEnN(slowWrEnN), .memDin(slowDin), .memDout(slowDout));
	// 25 MHz clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One request, bounded waits so a hang ends in the report
	task automatic access(input logic wr, input logic [15:0] a, input logic [3:0] d);
		int i = 0;
		while (reqReady !== 1'b1 && i < 40) begin
			@(negedge ref_clk);
			i++;
		end
		check("ready before request", 1'b1, reqReady);
		check("slow grade ready", 1'b1, slowReady);
		{reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, wr, a, d};
		@(negedge ref_clk);
		reqValid = 0;
		check("ready after take", 1'b0, reqReady);
		while (rspValid !== 1'b1 && i < 40) begin
			@(negedge ref_clk);
			i++;
		end
		check("answer in time", 1'b1, rspValid);
		check("slow grade answer", 1'b1, slowRsp);
		check("deselected at answer", 1'b1, memSelN);
		check("slow grade deselected", 1'b1, slowSelN);
		check("write enable at answer", 1'b1, memWrEnN);
		if (wr) begin
			check("address after write", a, memAddr);
			check("data after write", d, memDin);
		end
		// A missing answer was counted above; end the run rather than hang
		if (rspValid !== 1'b1) tally_and_finish();
	endtask
	////////////////////////////////////////////////////////////////
	task automatic sc_reset();
		check("select in reset", 1'b1, memSelN);
		check("write enable in reset", 1'b1, memWrEnN);
		check("ready in reset", 1'b1, reqReady);
	endtask
	// Corner addresses, written then read back
	task automatic sc_write_read();
		logic [15:0] tab [4] = '{16'h0000, 16'hFFFF, 16'h5A5A, 16'h00F1};
		foreach (tab[k]) access(1'b1, tab[k], tab[k][7:4] ^ 4'h9);
		foreach (tab[k]) begin
			access(1'b0, tab[k], 4'h0);
			check("read data", tab[k][7:4] ^ 4'h9, rspRdata);
			check("slow read data", tab[k][7:4] ^ 4'h9, slowRdata);
		end
	endtask
	// Overwrite then read at once, old value must be gone
	task automatic sc_overwrite();
		access(1'b1, 16'h1234, 4'h3);
		access(1'b1, 16'h1234, 4'hC);
		access(1'b0, 16'h1234, 4'h0);
		check("overwrite read", 4'hC, rspRdata);
		check("slow overwrite read", 4'hC, slowRdata);
	endtask
	// Reset in mid-write parks both strobes high; memory keeps earlier data
	task automatic sc_mid_reset();
		repeat (4) @(negedge ref_clk);
		check("ready before write", 1'b1, reqReady);
		{reqValid, reqWrite, reqAddr, reqWdata} = {1'b1, 1'b1, 16'h0BEE, 4'hA};
		@(negedge ref_clk);
		reqValid = 0;
		repeat (3) @(negedge ref_clk);
		check("strobe low in write", 1'b0, memWrEnN);
		nrst = 0;
		@(negedge ref_clk);
		check("select in mid reset", 1'b1, memSelN);
		check("write enable in mid reset", 1'b1, memWrEnN);
		check("no answer in reset", 1'b0, rspValid);
		check("ready in mid reset", 1'b1, reqReady);
		@(negedge ref_clk);
		nrst = 1;
		@(negedge ref_clk);
		access(1'b0, 16'h1234, 4'h0);
		check("read after reset", 4'hC, rspRdata);
	endtask
	initial begin
		repeat (16) @(negedge ref_clk);
		sc_reset();
		nrst = 1;
		@(negedge ref_clk);
		sc_write_read();
		sc_overwrite();
		sc_mid_reset();
		tally_and_finish();
	end
endmodule
